/* port_phy_control_cable_test.sv */
// Register access, mode resolution and per-port wiring for two transceiver ports
`timescale 1ns/1ps
module port_phy_control_cable_test #(
   parameter int unsigned DIAG_TIMEOUT_CYCLES = phy_ctl_pkg::DIAG_TIMEOUT_CYC,
   parameter int unsigned NIBBLE_W = phy_ctl_pkg::NIBBLE_W
) (
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   // Management register port
   input wire logic [7:0] REG_ADDR_I,
   input wire logic REG_WR_I,
   input wire logic [7:0] REG_WDATA_I,
   input wire logic REG_RD_I,
   output logic [7:0] REG_RDATA_O,
   output logic REG_RVALID_O,
   // Configuration straps
   input wire logic PORT1_AUTONEG_STRAP_I,
   input wire logic PORT1_SPEED_STRAP_I,
   input wire logic PORT1_DUPLEX_STRAP_I,
   input wire logic PORT2_AUTONEG_STRAP_I,
   input wire logic PORT2_SPEED_STRAP_I,
   input wire logic PORT2_DUPLEX_STRAP_I,
   // Link state from the transceivers, bit 0 is port 1
   input wire logic [1:0] LINK_DETECT_I,
   input wire logic [1:0] AN_FAILED_I,
   input wire logic [1:0] AN_SPEED_100_I,
   input wire logic [1:0] AN_FULL_DUPLEX_I,
   // Cable measurement handshake
   output logic [1:0] DIAG_START_O,
   input wire logic [1:0] DIAG_DONE_I,
   input wire logic [3:0] DIAG_RESULT_I,
   input wire logic [1:0] DIAG_SHORT_I,
   input wire logic [17:0] DIAG_COUNT_I,
   // Symbol paths toward the line
   input wire logic [2*NIBBLE_W-1:0] LINE_RX_DATA_I,
   input wire logic [1:0] LINE_RX_VALID_I,
   input wire logic [2*NIBBLE_W-1:0] MAC_TX_DATA_I,
   input wire logic [1:0] MAC_TX_VALID_I,
   output logic [2*NIBBLE_W-1:0] LINE_TX_DATA_O,
   output logic [1:0] LINE_TX_VALID_O,
   // Resolved operating mode per port
   output logic [1:0] LINK_PASS_O,
   output logic [1:0] AN_ENABLE_O,
   output logic [1:0] SPEED_100_O,
   output logic [1:0] FULL_DUPLEX_O,
   output logic [9:0] ADVERTISE_O,
   output logic [1:0] REMOTE_LOOPBACK_O
);

   localparam int unsigned NP = phy_ctl_pkg::NUM_PORTS;
   localparam int unsigned CW = phy_ctl_pkg::FAULT_COUNT_W;
   localparam int unsigned AW = phy_ctl_pkg::ADV_W;

   // Refuse settings that the watchdog or the data path cannot serve
   if (DIAG_TIMEOUT_CYCLES < 2) begin : g_bad_timeout
      $error("DIAG_TIMEOUT_CYCLES must be at least 2");
   end
   if (NIBBLE_W < 1) begin : g_bad_width
      $error("NIBBLE_W must be at least 1");
   end

   typedef struct packed {
      logic [7:0] rdata;
      logic rvalid;
      logic strap_done;
      logic [1:0] link_pass;
      logic [1:0] speed_100;
      logic [1:0] full_duplex;
   } top_state_t;

   localparam top_state_t TOP_RESET = '{
      rdata: phy_ctl_pkg::RDATA_RESET, rvalid: 1'b0, strap_done: 1'b0,
      link_pass: 2'h0, speed_100: 2'h0, full_duplex: 2'h0};

   top_state_t st_ff;
   top_state_t nxt_st;

   logic [NP-1:0] strap_an;
   logic [NP-1:0] strap_speed;
   logic [NP-1:0] strap_duplex;
   logic [NP-1:0] hit_special;
   logic [NP-1:0] hit_dist;
   logic [NP-1:0] hit_ctrl;
   logic [NP-1:0][7:0] special_q;
   logic [NP-1:0][7:0] dist_q;
   logic [NP-1:0][7:0] ctrl_q;
   logic [NP-1:0] force_link;
   logic [NP-1:0] rem_loop;
   logic wr_ok;
   logic load_straps;

   // Gather the per-port strap pins in port order
   assign strap_an = {PORT2_AUTONEG_STRAP_I, PORT1_AUTONEG_STRAP_I};
   assign strap_speed = {PORT2_SPEED_STRAP_I, PORT1_SPEED_STRAP_I};
   assign strap_duplex = {PORT2_DUPLEX_STRAP_I, PORT1_DUPLEX_STRAP_I};

   // Straps are caught in the first cycle after reset; writes wait one cycle
   // so a strap value is never overwritten by a racing software write
   assign load_straps = ~st_ff.strap_done;
   assign wr_ok = REG_WR_I & st_ff.strap_done;

   // Address decode; the third port's copies match nothing and stay inert
   always_comb begin
      for (int p = 0; p < NP; p++) begin
         hit_special[p] = (REG_ADDR_I == phy_ctl_pkg::SPECIAL_ADDR[p]);
         hit_dist[p] = (REG_ADDR_I == phy_ctl_pkg::DIST_ADDR[p]);
         hit_ctrl[p] = (REG_ADDR_I == phy_ctl_pkg::CTRL_ADDR[p]);
      end
   end

   // One register copy and one loopback path per port
   for (genvar p = 0; p < NP; p++) begin : g_port
      phy_port_regs #(
         .TIMEOUT_CYCLES(DIAG_TIMEOUT_CYCLES)
      ) u_regs (
         .clk_i(REF_CLK_I),
         .rst_i(RST_I),
         .load_straps_i(load_straps),
         .strap_an_i(strap_an[p]),
         .strap_speed_i(strap_speed[p]),
         .strap_duplex_i(strap_duplex[p]),
         .wr_special_i(wr_ok & hit_special[p]),
         .wr_ctrl_i(wr_ok & hit_ctrl[p]),
         .wdata_i(REG_WDATA_I),
         .diag_done_i(DIAG_DONE_I[p]),
         .diag_result_i(DIAG_RESULT_I[2*p +: 2]),
         .diag_short_i(DIAG_SHORT_I[p]),
         .diag_count_i(DIAG_COUNT_I[CW*p +: CW]),
         .special_o(special_q[p]),
         .dist_o(dist_q[p]),
         .ctrl_o(ctrl_q[p]),
         .diag_start_o(DIAG_START_O[p]),
         .force_link_o(force_link[p]),
         .rem_loop_o(rem_loop[p])
      );

      phy_loop_path #(
         .WIDTH(NIBBLE_W)
      ) u_loop (
         .clk_i(REF_CLK_I),
         .rst_i(RST_I),
         .loop_en_i(rem_loop[p]),
         .rx_data_i(LINE_RX_DATA_I[NIBBLE_W*p +: NIBBLE_W]),
         .rx_valid_i(LINE_RX_VALID_I[p]),
         .tx_data_i(MAC_TX_DATA_I[NIBBLE_W*p +: NIBBLE_W]),
         .tx_valid_i(MAC_TX_VALID_I[p]),
         .line_data_o(LINE_TX_DATA_O[NIBBLE_W*p +: NIBBLE_W]),
         .line_valid_o(LINE_TX_VALID_O[p])
      );

      // Register fields straight onto the mode pins
      assign AN_ENABLE_O[p] = ctrl_q[p][phy_ctl_pkg::CTRL_AN_EN_BIT];
      assign ADVERTISE_O[AW*p +: AW] = ctrl_q[p][phy_ctl_pkg::CTRL_ADV_HI:0];
      assign REMOTE_LOOPBACK_O[p] = rem_loop[p];
   end

   // Read mux, link pass and mode resolution, strap bookkeeping
   always_comb begin
      nxt_st = st_ff;
      nxt_st.strap_done = 1'b1;
      nxt_st.rvalid = REG_RD_I;
      if (REG_RD_I) begin
         // Unmapped and reserved addresses read zero
         nxt_st.rdata = phy_ctl_pkg::UNMAPPED_DATA;
         for (int p = 0; p < NP; p++) begin
            if (hit_special[p]) begin
               nxt_st.rdata = special_q[p];
            end
            if (hit_dist[p]) begin
               nxt_st.rdata = dist_q[p];
            end
            if (hit_ctrl[p]) begin
               nxt_st.rdata = ctrl_q[p];
            end
         end
      end
      for (int p = 0; p < NP; p++) begin
         // Forced pass overrides what the detector sees
         nxt_st.link_pass[p] = LINK_DETECT_I[p] | force_link[p];
         // Negotiated speed only counts while negotiation is on
         if (ctrl_q[p][phy_ctl_pkg::CTRL_AN_EN_BIT]) begin
            nxt_st.speed_100[p] = AN_SPEED_100_I[p];
         end else begin
            nxt_st.speed_100[p] = ctrl_q[p][phy_ctl_pkg::CTRL_SPEED_BIT];
         end
         // Duplex falls back to the forced bit when negotiation fails
         if (ctrl_q[p][phy_ctl_pkg::CTRL_AN_EN_BIT] & ~AN_FAILED_I[p]) begin
            nxt_st.full_duplex[p] = AN_FULL_DUPLEX_I[p];
         end else begin
            nxt_st.full_duplex[p] = ctrl_q[p][phy_ctl_pkg::CTRL_DUPLEX_BIT];
         end
      end
   end

   // State register
   always_ff @(posedge REF_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         st_ff <= TOP_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Registered outputs
   assign REG_RDATA_O = st_ff.rdata;
   assign REG_RVALID_O = st_ff.rvalid;
   assign LINK_PASS_O = st_ff.link_pass;
   assign SPEED_100_O = st_ff.speed_100;
   assign FULL_DUPLEX_O = st_ff.full_duplex;

endmodule : port_phy_control_cable_test

/* phy_ctl_pkg.sv */
// Shared constants and types for the port transceiver control register block
package phy_ctl_pkg;

   // Geometry
   localparam int unsigned NUM_PORTS = 2;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned FAULT_COUNT_W = 9;
   localparam int unsigned NIBBLE_W = 4;

   // Register offsets, index 0 is port 1, index 1 is port 2
   localparam logic [1:0][7:0] SPECIAL_ADDR = {8'h2a, 8'h1a};
   localparam logic [1:0][7:0] DIST_ADDR = {8'h2b, 8'h1b};
   localparam logic [1:0][7:0] CTRL_ADDR = {8'h2c, 8'h1c};
   // Third port copies, reserved
   localparam logic [7:0] P3_SPECIAL_ADDR = 8'h3a;
   localparam logic [7:0] P3_DIST_ADDR = 8'h3b;
   localparam logic [7:0] P3_CTRL_ADDR = 8'h3c;

   // Special control/status fields
   localparam int unsigned SC_SHORT_BIT = 7;
   localparam int unsigned SC_RESULT_HI = 6;
   localparam int unsigned SC_RESULT_LO = 5;
   localparam int unsigned SC_DIAG_EN_BIT = 4;
   localparam int unsigned SC_FORCE_LINK_BIT = 3;
   localparam int unsigned SC_REM_LOOP_BIT = 1;
   localparam int unsigned SC_COUNT_MSB_BIT = 0;
   localparam logic SC_RESERVED_VAL = 1'b0;

   // Link control fields
   localparam int unsigned CTRL_AN_EN_BIT = 7;
   localparam int unsigned CTRL_SPEED_BIT = 6;
   localparam int unsigned CTRL_DUPLEX_BIT = 5;
   localparam int unsigned CTRL_ADV_HI = 4;
   localparam int unsigned ADV_W = 5;

   // Reset values
   localparam logic [7:0] CTRL_RESET = 8'hff;
   localparam logic [7:0] DIST_RESET = 8'h00;
   localparam logic [7:0] RDATA_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_DATA = 8'h00;

   // Diagnostic result codes
   localparam logic [1:0] DIAG_NORMAL = 2'h0;
   localparam logic [1:0] DIAG_OPEN = 2'h1;
   localparam logic [1:0] DIAG_FAILED = 2'h3;

   // Fault distance step, millimetres per count
   localparam int unsigned FAULT_STEP_MM = 400;

   // Diagnostic watchdog: longest wait for the analog side
   localparam int unsigned CLK_PERIOD_PS = 5000;
   localparam int unsigned DIAG_TIMEOUT_NS = 100000;
   localparam int unsigned DIAG_TIMEOUT_CYC = (DIAG_TIMEOUT_NS * 1000) / CLK_PERIOD_PS;

   typedef enum logic {
      DIAG_IDLE = 1'b0,
      DIAG_RUN = 1'b1
   } diag_state_t;

endpackage : phy_ctl_pkg

/* phy_port_regs.sv */
// One port's special control/status, fault count and link control registers
`timescale 1ns/1ps
module phy_port_regs #(
   parameter int unsigned TIMEOUT_CYCLES = phy_ctl_pkg::DIAG_TIMEOUT_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic load_straps_i,
   input wire logic strap_an_i,
   input wire logic strap_speed_i,
   input wire logic strap_duplex_i,
   input wire logic wr_special_i,
   input wire logic wr_ctrl_i,
   input wire logic [7:0] wdata_i,
   input wire logic diag_done_i,
   input wire logic [1:0] diag_result_i,
   input wire logic diag_short_i,
   input wire logic [8:0] diag_count_i,
   output logic [7:0] special_o,
   output logic [7:0] dist_o,
   output logic [7:0] ctrl_o,
   output logic diag_start_o,
   output logic force_link_o,
   output logic rem_loop_o
);

   localparam int unsigned TW = $clog2(TIMEOUT_CYCLES + 1);
   localparam logic [TW-1:0] TIMER_LAST = TW'(TIMEOUT_CYCLES - 1);
   localparam logic [TW-1:0] TIMER_ZERO = '0;

   typedef struct packed {
      phy_ctl_pkg::diag_state_t state;
      logic [TW-1:0] timer;
      logic short_flag;
      logic [1:0] result;
      logic [8:0] count;
      logic force_link;
      logic rem_loop;
      logic [7:0] ctrl;
      logic start;
   } port_state_t;

   localparam port_state_t STATE_RESET = '{
      state: phy_ctl_pkg::DIAG_IDLE, timer: TIMER_ZERO, short_flag: 1'b0,
      result: phy_ctl_pkg::DIAG_NORMAL, count: 9'h000, force_link: 1'b0,
      rem_loop: 1'b0, ctrl: phy_ctl_pkg::CTRL_RESET, start: 1'b0};

   port_state_t st_ff;
   port_state_t nxt_st;
   logic start_req;
   logic finish;

   // Completion or watchdog expiry ends a running test
   assign start_req = wr_special_i & wdata_i[phy_ctl_pkg::SC_DIAG_EN_BIT];
   assign finish = (st_ff.state == phy_ctl_pkg::DIAG_RUN) &
                   (diag_done_i | (st_ff.timer == TIMER_LAST));

   // Next state of the whole port
   always_comb begin
      nxt_st = st_ff;
      nxt_st.start = 1'b0;
      if (wr_special_i) begin
         nxt_st.force_link = wdata_i[phy_ctl_pkg::SC_FORCE_LINK_BIT];
         nxt_st.rem_loop = wdata_i[phy_ctl_pkg::SC_REM_LOOP_BIT];
      end
      if (wr_ctrl_i) begin
         nxt_st.ctrl = wdata_i;
      end
      if (load_straps_i) begin
         nxt_st.ctrl[phy_ctl_pkg::CTRL_AN_EN_BIT] = strap_an_i;
         nxt_st.ctrl[phy_ctl_pkg::CTRL_SPEED_BIT] = strap_speed_i;
         nxt_st.ctrl[phy_ctl_pkg::CTRL_DUPLEX_BIT] = strap_duplex_i;
      end
      unique case (st_ff.state)
         phy_ctl_pkg::DIAG_IDLE: begin
            nxt_st.timer = TIMER_ZERO;
         end
         phy_ctl_pkg::DIAG_RUN: begin
            nxt_st.timer = st_ff.timer + TW'(1);
            if (finish) begin
               nxt_st.state = phy_ctl_pkg::DIAG_IDLE;
               if (diag_done_i) begin
                  nxt_st.short_flag = diag_short_i;
                  nxt_st.result = diag_result_i;
                  nxt_st.count = diag_count_i;
               end else begin
                  // No answer from the analog side: report a failed test
                  nxt_st.short_flag = 1'b0;
                  nxt_st.result = phy_ctl_pkg::DIAG_FAILED;
                  nxt_st.count = 9'h000;
               end
            end
         end
      endcase
      // A start that meets completion wins and launches the next test
      if (start_req & ((st_ff.state == phy_ctl_pkg::DIAG_IDLE) | finish)) begin
         nxt_st.state = phy_ctl_pkg::DIAG_RUN;
         nxt_st.timer = TIMER_ZERO;
         nxt_st.start = 1'b1;
      end
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_ff <= STATE_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Read views; the enable bit reads one while a test runs
   assign special_o = {st_ff.short_flag, st_ff.result,
                       st_ff.state == phy_ctl_pkg::DIAG_RUN, st_ff.force_link,
                       phy_ctl_pkg::SC_RESERVED_VAL, st_ff.rem_loop,
                       st_ff.count[phy_ctl_pkg::FAULT_COUNT_W-1]};
   assign dist_o = st_ff.count[7:0];
   assign ctrl_o = st_ff.ctrl;
   assign diag_start_o = st_ff.start;
   assign force_link_o = st_ff.force_link;
   assign rem_loop_o = st_ff.rem_loop;

endmodule : phy_port_regs

/* phy_loop_path.sv */
// Transmit-side selector that turns line receive data around in remote loopback
`timescale 1ns/1ps
module phy_loop_path #(
   parameter int unsigned WIDTH = phy_ctl_pkg::NIBBLE_W
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic loop_en_i,
   input wire logic [WIDTH-1:0] rx_data_i,
   input wire logic rx_valid_i,
   input wire logic [WIDTH-1:0] tx_data_i,
   input wire logic tx_valid_i,
   output logic [WIDTH-1:0] line_data_o,
   output logic line_valid_o
);

   typedef struct packed {
      logic [WIDTH-1:0] data;
      logic valid;
   } path_state_t;

   path_state_t st_ff;
   path_state_t nxt_st;

   // Loopback turns received symbols straight back; switch traffic is cut off
   always_comb begin
      if (loop_en_i) begin
         nxt_st = '{data: rx_data_i, valid: rx_valid_i};
      end else begin
         nxt_st = '{data: tx_data_i, valid: tx_valid_i};
      end
   end

   // One register stage toward the line
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign line_data_o = st_ff.data;
   assign line_valid_o = st_ff.valid;

endmodule : phy_loop_path

/* port_phy_control_cable_test_properties.sv */
// Port-level checks for the port transceiver control register block
`timescale 1ns/1ps
module port_phy_ctl_checker #(
   parameter int unsigned NIBBLE_W = 4
) (
   input wire logic REF_CLK_I,
   input wire logic RST_I,
   input wire logic [7:0] REG_ADDR_I,
   input wire logic REG_WR_I,
   input wire logic REG_RD_I,
   input wire logic [7:0] REG_RDATA_O,
   input wire logic REG_RVALID_O,
   input wire logic [1:0] LINK_DETECT_I,
   input wire logic [1:0] AN_FAILED_I,
   input wire logic [1:0] AN_SPEED_100_I,
   input wire logic [1:0] AN_FULL_DUPLEX_I,
   input wire logic [2*NIBBLE_W-1:0] LINE_RX_DATA_I,
   input wire logic [1:0] LINE_RX_VALID_I,
   input wire logic [1:0] MAC_TX_VALID_I,
   input wire logic [2*NIBBLE_W-1:0] LINE_TX_DATA_O,
   input wire logic [1:0] LINE_TX_VALID_O,
   input wire logic [1:0] LINK_PASS_O,
   input wire logic [1:0] AN_ENABLE_O,
   input wire logic [1:0] SPEED_100_O,
   input wire logic [1:0] FULL_DUPLEX_O,
   input wire logic [9:0] ADVERTISE_O,
   input wire logic [1:0] REMOTE_LOOPBACK_O
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);

   property p_read_answer;
      ##1 REG_RVALID_O == $past(REG_RD_I);
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read answer late");
   property p_unmapped_zero;
      REG_RD_I && REG_ADDR_I == 8'h3c |=> REG_RVALID_O && REG_RDATA_O == 8'h00;
   endproperty
   a_unmapped_zero: assert property (p_unmapped_zero) else $error("reserved read");
   property p_link_pass_detect;
      LINK_DETECT_I[0] |=> LINK_PASS_O[0];
   endproperty
   a_link_pass_detect: assert property (p_link_pass_detect) else $error("link pass 1");
   property p_link_pass_port2;
      LINK_DETECT_I[1] |=> LINK_PASS_O[1];
   endproperty
   a_link_pass_port2: assert property (p_link_pass_port2) else $error("link pass 2");
   property p_an_speed;
      AN_ENABLE_O[0] && !AN_FAILED_I[0] |=> SPEED_100_O[0] == $past(AN_SPEED_100_I[0]);
   endproperty
   a_an_speed: assert property (p_an_speed) else $error("negotiated speed");
   property p_an_duplex;
      AN_ENABLE_O[0] && !AN_FAILED_I[0] |=> FULL_DUPLEX_O[0] == $past(AN_FULL_DUPLEX_I[0]);
   endproperty
   a_an_duplex: assert property (p_an_duplex) else $error("negotiated duplex");
   property p_loop_turn;
      REMOTE_LOOPBACK_O[0] && LINE_RX_VALID_I[0] |=> LINE_TX_VALID_O[0] &&
         LINE_TX_DATA_O[NIBBLE_W-1:0] == $past(LINE_RX_DATA_I[NIBBLE_W-1:0]);
   endproperty
   a_loop_turn: assert property (p_loop_turn) else $error("loopback data");
   property p_loop_off;
      !REMOTE_LOOPBACK_O[0] |=> LINE_TX_VALID_O[0] == $past(MAC_TX_VALID_I[0]);
   endproperty
   a_loop_off: assert property (p_loop_off) else $error("normal transmit");
   property p_advert_hold;
      !REG_WR_I |=> $stable(ADVERTISE_O);
   endproperty
   a_advert_hold: assert property (p_advert_hold) else $error("advertise moved");
endmodule : port_phy_ctl_checker

bind port_phy_control_cable_test port_phy_ctl_checker #(.NIBBLE_W(NIBBLE_W)) u_chk (
   .REF_CLK_I, .RST_I, .REG_ADDR_I, .REG_WR_I, .REG_RD_I, .REG_RDATA_O, .REG_RVALID_O,
   .LINK_DETECT_I, .AN_FAILED_I, .AN_SPEED_100_I, .AN_FULL_DUPLEX_I, .LINE_RX_DATA_I,
   .LINE_RX_VALID_I, .MAC_TX_VALID_I, .LINE_TX_DATA_O, .LINE_TX_VALID_O, .LINK_PASS_O,
   .AN_ENABLE_O, .SPEED_100_O, .FULL_DUPLEX_O, .ADVERTISE_O, .REMOTE_LOOPBACK_O);

/* cable_partner_model.sv */
// Behavioural analog cable measurement side for both ports
`timescale 1ns/1ps
module cable_partner_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [1:0] start_i,
   input wire logic silent_i,
   input wire logic [7:0] lat_i,
   input wire logic [1:0] res_i,
   input wire logic short_i,
   input wire logic [8:0] cnt_i,
   output logic [1:0] done_o,
   output logic [3:0] result_o,
   output logic [17:0] count_o,
   output logic [1:0] short_o
);
   int wait_c [2];
   // Outside the done pulse the lines toggle, so stale values never look valid
   always @(negedge clk_i) begin
      for (int p = 0; p < 2; p++) begin
         done_o[p] <= 1'b0;
         result_o[2*p+:2] <= rst_i ? 2'h0 : ~result_o[2*p+:2];
         count_o[9*p+:9] <= rst_i ? 9'h000 : ~count_o[9*p+:9];
         short_o[p] <= rst_i ? 1'b0 : ~short_o[p];
         if (rst_i) begin
            wait_c[p] = 0;
         end else if (start_i[p]) begin
            wait_c[p] = lat_i;
         end else if (wait_c[p] > 0) begin
            wait_c[p]--;
            // Silent mode models a measurement that never reports
            if (wait_c[p] == 0 && !silent_i) begin
               done_o[p] <= 1'b1;
               result_o[2*p+:2] <= res_i;
               count_o[9*p+:9] <= cnt_i;
               short_o[p] <= short_i;
            end
         end
      end
   end
endmodule : cable_partner_model

/* port_phy_control_cable_test_tb_top.sv */
// Self-checking bench for the port transceiver control register block
`timescale 1ns/1ps
module port_phy_control_cable_test_tb_top;
   logic ref_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rvalid, silent = 1'b0, m_short = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, rx_d = 8'h00, tx_d = 8'h00, line_d;
   logic [7:0] lat = 8'h04, seed = 8'h62, v;
   logic [5:0] straps = 6'h00;
   logic [1:0] link_det = 2'h0, an_fail = 2'h0, an_spd = 2'h0, an_fdx = 2'h0, m_res = 2'h0;
   logic [1:0] rx_v = 2'h0, tx_v = 2'h0, line_v, link_pass, an_en, spd, fdx, rloop;
   logic [1:0] d_start, d_done, d_short;
   logic [3:0] d_res;
   logic [17:0] d_cnt;
   logic [9:0] adv;
   logic [8:0] m_cnt = 9'h000;
   logic [7:0] ctrl_sh [2];
   int n_fail = 0, checks = 0, n_start = 0;

   always #2.5 ref_clk = ~ref_clk;

   port_phy_control_cable_test #(.DIAG_TIMEOUT_CYCLES(16), .NIBBLE_W(4)) uut (
      .REF_CLK_I(ref_clk), .RST_I(rst), .REG_ADDR_I(addr), .REG_WR_I(wr),
      .REG_WDATA_I(wdata), .REG_RD_I(rd), .REG_RDATA_O(rdata), .REG_RVALID_O(rvalid),
      .PORT1_AUTONEG_STRAP_I(straps[0]), .PORT1_SPEED_STRAP_I(straps[1]),
      .PORT1_DUPLEX_STRAP_I(straps[2]), .PORT2_AUTONEG_STRAP_I(straps[3]),
      .PORT2_SPEED_STRAP_I(straps[4]), .PORT2_DUPLEX_STRAP_I(straps[5]),
      .LINK_DETECT_I(link_det), .AN_FAILED_I(an_fail), .AN_SPEED_100_I(an_spd),
      .AN_FULL_DUPLEX_I(an_fdx), .DIAG_START_O(d_start), .DIAG_DONE_I(d_done),
      .DIAG_RESULT_I(d_res), .DIAG_SHORT_I(d_short), .DIAG_COUNT_I(d_cnt),
      .LINE_RX_DATA_I(rx_d), .LINE_RX_VALID_I(rx_v), .MAC_TX_DATA_I(tx_d),
      .MAC_TX_VALID_I(tx_v), .LINE_TX_DATA_O(line_d), .LINE_TX_VALID_O(line_v),
      .LINK_PASS_O(link_pass), .AN_ENABLE_O(an_en), .SPEED_100_O(spd),
      .FULL_DUPLEX_O(fdx), .ADVERTISE_O(adv), .REMOTE_LOOPBACK_O(rloop));

   cable_partner_model u_cable (.clk_i(ref_clk), .rst_i(rst), .start_i(d_start),
      .silent_i(silent), .lat_i(lat), .res_i(m_res), .short_i(m_short), .cnt_i(m_cnt),
      .done_o(d_done), .result_o(d_res), .count_o(d_cnt), .short_o(d_short));

   // Count measurement launches seen by the analog side
   always @(posedge ref_clk) n_start += d_start[0] + d_start[1];

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   // Expected special register after a finished measurement, other bits clear
   function automatic logic [7:0] exp_sc(input logic sh, input logic [1:0] r, input logic [8:0] c);
      return {sh, r, 4'h0, c[8]};
   endfunction : exp_sc

   task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error %s expected %0h seen %0h", name, exp, seen);
      end
   endtask : check

   task automatic complete_run();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : complete_run

   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge ref_clk);
      wr = 1'b0;
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
      @(negedge ref_clk);
      rd = 1'b1;
      addr = a;
      @(negedge ref_clk);
      rd = 1'b0;
      check("rvalid", rvalid, 1'b1);
      d = rdata;
   endtask : rd_reg

   // Straps are random and held across release, where they are captured
   task automatic do_reset();
      @(negedge ref_clk);
      rst = 1'b1;
      seed = lfsr(seed);
      straps = seed[5:0];
      repeat (2) @(negedge ref_clk);
      check("an_en_rst", an_en, 2'h3);
      check("adv_rst", adv, 10'h3ff);
      rst = 1'b0;
      repeat (3) @(negedge ref_clk);
      for (int p = 0; p < 2; p++) begin
         ctrl_sh[p] = {straps[3*p], straps[3*p+1], straps[3*p+2], 5'h1f};
         rd_reg(phy_ctl_pkg::CTRL_ADDR[p], v);
         check("ctrl_rst", v, ctrl_sh[p]);
         rd_reg(phy_ctl_pkg::SPECIAL_ADDR[p], v);
         check("special_rst", v, 8'h00);
         rd_reg(phy_ctl_pkg::DIST_ADDR[p], v);
         check("dist_rst", v, phy_ctl_pkg::DIST_RESET);
      end
   endtask : do_reset

   initial begin
      repeat (20000) @(posedge ref_clk);
      n_fail++;
      complete_run();
   end

   initial begin
      int p, n0;
      do_reset();
      do_reset();
      // Random mode settings, the other port must keep its copy
      repeat (8) begin
         seed = lfsr(seed);
         p = seed[0];
         an_fail = seed[2:1];
         an_spd = seed[4:3];
         an_fdx = seed[6:5];
         v = lfsr(seed);
         v[5] = v[5] & ~v[7];
         ctrl_sh[p] = v;
         wr_reg(phy_ctl_pkg::CTRL_ADDR[p], v);
         repeat (2) @(negedge ref_clk);
         check("an_en", an_en[p], v[7]);
         check("adv", adv[5*p+:5], v[4:0]);
         check("duplex", fdx[p], (v[7] && !an_fail[p]) ? an_fdx[p] : v[5]);
         if (!v[7] || !an_fail[p])
            check("speed", spd[p], v[7] ? an_spd[p] : v[6]);
         rd_reg(phy_ctl_pkg::CTRL_ADDR[1-p], v);
         check("ctrl_other", v, ctrl_sh[1-p]);
      end
      for (p = 0; p < 2; p++) begin
         // Force link with the detector low, reserved bit kept at zero
         link_det = 2'h0;
         wr_reg(phy_ctl_pkg::SPECIAL_ADDR[p], 8'h08);
         repeat (2) @(negedge ref_clk);
         check("force_pass", link_pass, 2'h1 << p);
         rd_reg(phy_ctl_pkg::SPECIAL_ADDR[p], v);
         check("special_rb", v, 8'h08);
         wr_reg(phy_ctl_pkg::SPECIAL_ADDR[p], 8'h02);
         repeat (2) @(negedge ref_clk);
         check("force_off", link_pass, 2'h0);
         check("loop_bit", rloop, 2'h1 << p);
         repeat (6) begin
            seed = lfsr(seed);
            rx_d = seed;
            tx_d = ~seed;
            rx_v = 2'h3;
            tx_v = seed[1:0];
            link_det = seed[3:2];
            @(negedge ref_clk);
            check("loop_data", line_d[4*p+:4], rx_d[4*p+:4]);
            check("loop_valid", line_v[p], rx_v[p]);
            check("other_data", line_d[4*(1-p)+:4], tx_d[4*(1-p)+:4]);
            check("link_follow", link_pass, link_det);
         end
         wr_reg(phy_ctl_pkg::SPECIAL_ADDR[p], 8'h00);
         // Normal, open, failed codes, then a measurement that never reports
         for (int k = 0; k < 4; k++) begin
            seed = lfsr(seed);
            m_res = (k == 0) ? phy_ctl_pkg::DIAG_NORMAL :
               (k == 1) ? phy_ctl_pkg::DIAG_OPEN : phy_ctl_pkg::DIAG_FAILED;
            m_short = seed[0];
            m_cnt = {seed[1], lfsr(seed)};
            silent = (k == 3);
            lat = 8'h03 + seed[2:0];
            n0 = n_start;
            wr_reg(phy_ctl_pkg::SPECIAL_ADDR[p], 8'h10);
            rd_reg(phy_ctl_pkg::SPECIAL_ADDR[p], v);
            check("diag_busy", v[4], 1'b1);
            for (int t = 0; t < 40 && v[4] !== 1'b0; t++)
               rd_reg(phy_ctl_pkg::SPECIAL_ADDR[p], v);
            if (silent)
               check("special_to", v, exp_sc(1'b0, 2'h3, 9'h000));
            else
               check("special", v, exp_sc(m_short, m_res, m_cnt));
            check("starts", n_start - n0, 1);
            rd_reg(phy_ctl_pkg::DIST_ADDR[p], v);
            check("dist", v, silent ? 8'h00 : m_cnt[7:0]);
            wr_reg(phy_ctl_pkg::DIST_ADDR[p], 8'hff);
            rd_reg(phy_ctl_pkg::DIST_ADDR[p], v);
            check("dist_ro", v, silent ? 8'h00 : m_cnt[7:0]);
         end
      end
      // Third port copies and an unmapped place stay empty
      wr_reg(phy_ctl_pkg::P3_SPECIAL_ADDR, 8'hff);
      rd_reg(phy_ctl_pkg::P3_SPECIAL_ADDR, v);
      check("p3_special", v, phy_ctl_pkg::UNMAPPED_DATA);
      rd_reg(phy_ctl_pkg::P3_CTRL_ADDR, v);
      check("p3_ctrl", v, phy_ctl_pkg::UNMAPPED_DATA);
      rd_reg(8'h50, v);
      check("unmapped", v, phy_ctl_pkg::UNMAPPED_DATA);
      complete_run();
   end
endmodule : port_phy_control_cable_test_tb_top
